// ---- core/css_pkg.sv ----
// Constants, register map and field layout for the configuration startup sequencer.
// Assumes a single 20 MHz clock domain and an AHB-Lite register bus with 32-bit data.
package css_pkg;

	// ==========================================================================
	// Register byte offsets.
	// ==========================================================================
	localparam logic [7:0] CSS_CFG_OFS = 8'h00;
	localparam logic [7:0] CSS_CMD_OFS = 8'h04;
	localparam logic [7:0] CSS_STAT_OFS = 8'h08;
	localparam logic [7:0] CSS_RBSEL_OFS = 8'h0c;
	localparam logic [7:0] CSS_RBDATA_OFS = 8'h10;

	// ==========================================================================
	// Field positions in the settings register.
	// ==========================================================================
	localparam int CSS_WE_LSB = 0;
	localparam int CSS_TS_LSB = 4;
	localparam int CSS_DONE_LSB = 8;
	localparam int CSS_CLK_LSB = 12;
	localparam int CSS_PULL_LSB = 14;
	localparam int CSS_RATE_LSB = 16;
	localparam int CSS_SEC_LSB = 20;

	// Command register bits.
	localparam int CSS_CMD_LOAD = 0;
	localparam int CSS_CMD_DONE_LOAD = 1;
	localparam int CSS_CMD_CLR_REFUSED = 2;

	// ==========================================================================
	// Phase selection encoding: 1 to 6 are phases, then wait-for-done and keep.
	// ==========================================================================
	localparam logic [3:0] CSS_SEL_DONE = 4'h7;
	localparam logic [3:0] CSS_SEL_KEEP = 4'h8;
	localparam logic [3:0] CSS_WE_RESET = 4'h6;
	localparam logic [3:0] CSS_TS_RESET = 4'h5;
	localparam logic [3:0] CSS_DONE_RESET = 4'h4;
	localparam logic [3:0] CSS_PHASE_MIN = 4'h1;
	localparam logic [3:0] CSS_PHASE_MAX = 4'h6;

	// Startup clock choices.
	localparam logic [1:0] CSS_CLK_CCLK = 2'h0;
	localparam logic [1:0] CSS_CLK_USER = 2'h1;
	localparam logic [1:0] CSS_CLK_JTAG = 2'h2;

	// Unused pin pull choices.
	localparam logic [1:0] CSS_PULL_DOWN = 2'h0;
	localparam logic [1:0] CSS_PULL_UP = 2'h1;
	localparam logic [1:0] CSS_PULL_NONE = 2'h2;

	// Oscillator rate codes 0..5 mean 1, 3, 6, 12, 25, 50 MHz; code 0 is the lowest.
	localparam logic [2:0] CSS_RATE_LOWEST = 3'h0;
	localparam logic [2:0] CSS_RATE_TOP = 3'h5;

	// Security levels; any non-zero level blocks readback.
	localparam logic [1:0] CSS_SEC_NONE = 2'h0;

	// Readback requester ports.
	localparam logic [1:0] CSS_PORT_PARALLEL = 2'h0;
	localparam logic [1:0] CSS_PORT_JTAG = 2'h1;

	// Readback source selection.
	localparam logic [1:0] CSS_RB_IMAGE = 2'h0;
	localparam logic [1:0] CSS_RB_FLOPS = 2'h1;
	localparam logic [1:0] CSS_RB_LUTMEM = 2'h2;
	localparam logic [1:0] CSS_RB_BLOCKMEM = 2'h3;

	localparam logic [31:0] CSS_CFG_RESET = 32'h0000_0456;

	// AHB-Lite encodings.
	localparam logic [1:0] CSS_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] CSS_HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		CSS_ST_IDLE,
		CSS_ST_LOAD,
		CSS_ST_STARTUP,
		CSS_ST_USER
	} css_seq_t;

endpackage

// ---- core/css_config_startup_sequencer.sv ----
// Configuration completion logic: readback gate, startup sequencer, oscillator rate and pull selection.
// Assumes all pins and startup clock sources are synchronous levels sampled on clock_i.
//
// Overview of operation
// - Readback is served only to the slave parallel or JTAG requester.
// - Any non-zero security level refuses all readback.
// - Readback returns image, captured flip-flops and captured distributed memory.
// - A synchronous capture input snapshots register and distributed memory values for readback; block memory is read live.
// - Slow commercial grade drops block memory readback, and all but image readback on large parts.
// - Oscillator rate code selects about 1, 3, 6, 12, 25 or 50 MHz.
// - Oscillator starts lowest; new rate applies only when the image finishes loading.
// - Rate setting defaults to the lowest choice, about 1 MHz.
// - By default the configuration clock steps the startup sequence.
// - User clock choice steps the sequence from the user-supplied clock.
// - JTAG choice steps the sequence from the test clock.
// - Unused pins default to pull-down; pull-up or floating are alternatives.
// - Completion pin release phase is selectable 1 to 6, default 4.
// - Write enable phase is selectable 1 to 6, default 6.
// - Wait-for-done holds write enable off until the completion pin reads high.
// - Keep choice retains the previously active write enable or tristate phase setting; for the completion pin it never releases.
// - Default order: tristate released after done, write enable one step later.
// - Tristate release phase is selectable, or waits for the completion pin.
// - Global set/reset holds through loading and pulses at the end.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

module css_config_startup_sequencer #(
	parameter bit SLOW_COMMERCIAL = 1'b0,
	parameter bit LARGE_DENSITY = 1'b0
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic [1:0] rb_port_i,
	input wire logic cclk_i,
	input wire logic user_clk_i,
	input wire logic tck_i,
	input wire logic capture_i,
	input wire logic [31:0] user_flops_i,
	input wire logic [31:0] lut_mem_i,
	input wire logic [31:0] block_mem_i,
	input wire logic done_pin_i,
	output logic done_pin_o,
	output logic done_pin_oe_n_o,
	output logic global_tristate_o,
	output logic global_write_enable_o,
	output logic global_set_reset_o,
	output logic [2:0] config_osc_rate_o,
	output logic [1:0] unused_pin_pull_sel_o,
	output logic [3:0] startup_phase_o
);
	import css_pkg::*;

	// ==========================================================================
	// State.
	// ==========================================================================
	typedef struct packed {
		logic [31:0] cfg;
		logic [1:0] rb_sel;
		logic rb_refused;
		logic [31:0] flops_snap;
		logic [31:0] lut_snap;
		css_seq_t seq;
		logic [3:0] phase;
		logic [3:0] we_active;
		logic [3:0] ts_active;
		logic [2:0] osc_rate;
		logic global_set_reset;
		logic gsr_pulse;
		logic done_rel;
		logic ts_rel;
		logic we_rel;
		logic cclk_d;
		logic user_clk_d;
		logic tck_d;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} css_state_t;

	css_state_t state_reg;
	css_state_t state_next;

	logic [3:0] we_sel;
	logic [3:0] ts_sel;
	logic [3:0] done_sel;
	logic [1:0] clk_sel;
	logic [1:0] sec_sel;
	logic step;
	logic wait_unmet;
	logic addr_phase;
	logic rb_allowed;
	logic [31:0] rb_word;

	// A phase selection is met once its phase is reached, or the pin reads high for the wait choice.
	function automatic logic css_release_due(input logic [3:0] sel, input logic [3:0] phase, input logic pin);
		if (sel == CSS_SEL_DONE) begin
			css_release_due = pin;
		end else begin
			css_release_due = (phase >= sel) && (sel >= CSS_PHASE_MIN) && (sel <= CSS_PHASE_MAX);
		end
	endfunction

	// Keep, or an out-of-range code, leaves the previous active selection in place.
	function automatic logic [3:0] css_pick_sel(input logic [3:0] sel, input logic [3:0] old);
		if (sel == CSS_SEL_KEEP || sel == 4'h0 || sel > CSS_SEL_KEEP) begin
			css_pick_sel = old;
		end else begin
			css_pick_sel = sel;
		end
	endfunction

	assign we_sel = state_reg.cfg[CSS_WE_LSB +: 4];
	assign ts_sel = state_reg.cfg[CSS_TS_LSB +: 4];
	assign done_sel = state_reg.cfg[CSS_DONE_LSB +: 4];
	assign clk_sel = state_reg.cfg[CSS_CLK_LSB +: 2];
	assign sec_sel = state_reg.cfg[CSS_SEC_LSB +: 2];

	// ==========================================================================
	// Startup clock selection and stepping.
	// ==========================================================================
	always_comb begin
		case (clk_sel)
			CSS_CLK_USER: step = user_clk_i && !state_reg.user_clk_d;
			CSS_CLK_JTAG: step = tck_i && !state_reg.tck_d;
			default: step = cclk_i && !state_reg.cclk_d;
		endcase
	end

	// The last phase is held until every wait-for-done release has seen the pin high.
	assign wait_unmet = (!css_release_due(state_reg.we_active, state_reg.phase, done_pin_i))
		|| (!css_release_due(state_reg.ts_active, state_reg.phase, done_pin_i));

	// ==========================================================================
	// Readback gate and source.
	// ==========================================================================
	assign rb_allowed = ((rb_port_i == CSS_PORT_PARALLEL) || (rb_port_i == CSS_PORT_JTAG))
		&& (sec_sel == CSS_SEC_NONE)
		&& !(SLOW_COMMERCIAL && LARGE_DENSITY && (state_reg.rb_sel != CSS_RB_IMAGE))
		&& !(SLOW_COMMERCIAL && (state_reg.rb_sel == CSS_RB_BLOCKMEM));

	always_comb begin
		case (state_reg.rb_sel)
			CSS_RB_FLOPS: rb_word = state_reg.flops_snap;
			CSS_RB_LUTMEM: rb_word = state_reg.lut_snap;
			CSS_RB_BLOCKMEM: rb_word = block_mem_i;
			default: rb_word = state_reg.cfg;
		endcase
	end

	assign addr_phase = hsel_i && hready_i && (htrans_i == CSS_HTRANS_NONSEQ);

	// ==========================================================================
	// Next state.
	// ==========================================================================
	always_comb begin
		state_next = state_reg;
		state_next.cclk_d = cclk_i;
		state_next.user_clk_d = user_clk_i;
		state_next.tck_d = tck_i;
		state_next.dp_wr = 1'b0;
		state_next.gsr_pulse = 1'b0;

		// User logic drives the capture strobe in its own clock domain, which is this one.
		if (capture_i) begin
			state_next.flops_snap = user_flops_i;
			state_next.lut_snap = lut_mem_i;
		end

		// Bus address phase: reads are answered from flops in the following data phase.
		if (addr_phase) begin
			state_next.dp_wr = hwrite_i && (hsize_i == CSS_HSIZE_WORD);
			state_next.dp_addr = haddr_i[7:0];
			state_next.rdata = 32'h0000_0000;
			if (!hwrite_i) begin
				case (haddr_i[7:0])
					CSS_CFG_OFS: state_next.rdata = state_reg.cfg;
					CSS_STAT_OFS: state_next.rdata = {15'h0000, state_reg.osc_rate, state_reg.rb_refused,
						rb_allowed, state_reg.global_set_reset, state_reg.we_rel, state_reg.ts_rel, state_reg.done_rel,
						state_reg.phase, 2'h0, state_reg.seq};
					CSS_RBSEL_OFS: state_next.rdata = {30'h0000_0000, state_reg.rb_sel};
					CSS_RBDATA_OFS: begin
						if (rb_allowed) begin
							state_next.rdata = rb_word;
						end else begin
							state_next.rdata = 32'h0000_0000;
							state_next.rb_refused = 1'b1;
						end
					end
					default: state_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Bus data phase: writes land here; a refusal set in the same cycle beats the clear.
		if (state_reg.dp_wr) begin
			case (state_reg.dp_addr)
				CSS_CFG_OFS: state_next.cfg = hwdata_i;
				CSS_RBSEL_OFS: state_next.rb_sel = hwdata_i[1:0];
				CSS_CMD_OFS: begin
					// A refusal raised by this cycle's address phase must survive the clear, even when already set.
					if (hwdata_i[CSS_CMD_CLR_REFUSED]
						&& !(addr_phase && !hwrite_i && (haddr_i[7:0] == CSS_RBDATA_OFS) && !rb_allowed)) begin
						state_next.rb_refused = 1'b0;
					end
					if (hwdata_i[CSS_CMD_LOAD]) begin
						state_next.seq = CSS_ST_LOAD;
						state_next.global_set_reset = 1'b1;
						state_next.done_rel = 1'b0;
						state_next.ts_rel = 1'b0;
						state_next.we_rel = 1'b0;
						state_next.phase = 4'h0;
					end else if (hwdata_i[CSS_CMD_DONE_LOAD] && state_reg.seq == CSS_ST_LOAD) begin
						// The rate in the image takes effect only now that loading has finished.
						if (state_reg.cfg[CSS_RATE_LSB +: 3] <= CSS_RATE_TOP) begin
							state_next.osc_rate = state_reg.cfg[CSS_RATE_LSB +: 3];
						end
						state_next.we_active = css_pick_sel(we_sel, state_reg.we_active);
						state_next.ts_active = css_pick_sel(ts_sel, state_reg.ts_active);
						state_next.global_set_reset = 1'b0;
						state_next.gsr_pulse = 1'b1;
						state_next.seq = CSS_ST_STARTUP;
					end
				end
				default: begin
				end
			endcase
		end

		// Startup phases advance only on the chosen clock's rising edge.
		if (state_reg.seq == CSS_ST_STARTUP && step) begin
			if (state_reg.phase < CSS_PHASE_MAX) begin
				state_next.phase = state_reg.phase + 4'h1;
			end
			if (css_release_due(done_sel, state_next.phase, 1'b0)) begin
				state_next.done_rel = 1'b1;
			end
			if (css_release_due(state_reg.ts_active, state_next.phase, done_pin_i)) begin
				state_next.ts_rel = 1'b1;
			end
			if (css_release_due(state_reg.we_active, state_next.phase, done_pin_i)) begin
				state_next.we_rel = 1'b1;
			end
			if (state_reg.phase == CSS_PHASE_MAX && !wait_unmet) begin
				state_next.seq = CSS_ST_USER;
			end
		end

		if (reset_i) begin
			state_next = '0;
			state_next.cfg = CSS_CFG_RESET;
			state_next.we_active = CSS_WE_RESET;
			state_next.ts_active = CSS_TS_RESET;
			state_next.osc_rate = CSS_RATE_LOWEST;
			state_next.seq = CSS_ST_IDLE;
		end
	end

	always_ff @(posedge clock_i) begin
		state_reg <= state_next;
	end

	// ==========================================================================
	// Outputs.
	// ==========================================================================
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = state_reg.rdata;
	// The completion pin is open drain: pulled low until its phase, then released.
	assign done_pin_o = 1'b0;
	assign done_pin_oe_n_o = state_reg.done_rel;
	assign global_tristate_o = !state_reg.ts_rel;
	assign global_write_enable_o = state_reg.we_rel;
	assign global_set_reset_o = state_reg.global_set_reset || state_reg.gsr_pulse;
	assign config_osc_rate_o = state_reg.osc_rate;
	assign unused_pin_pull_sel_o = state_reg.cfg[CSS_PULL_LSB +: 2];
	assign startup_phase_o = state_reg.phase;

endmodule // css_config_startup_sequencer

// ---- testbench/css_seq_chk.sv ----
// Port assertions for the configuration startup sequencer.
// Assumes one clock, clock_i, and a synchronous active-high reset_i.
`timescale 1ns/1ps
module css_seq_chk (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic done_pin_oe_n_o,
	input wire logic global_tristate_o,
	input wire logic global_write_enable_o,
	input wire logic global_set_reset_o,
	input wire logic [2:0] config_osc_rate_o,
	input wire logic [3:0] startup_phase_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	// ==========================================================================
	// Properties.
	property p_okay;
		hreadyout_o && !hresp_o;
	endproperty
	property p_step;
		!$stable(startup_phase_o) |-> startup_phase_o == $past(startup_phase_o) + 4'h1 || startup_phase_o == 4'h0;
	endproperty
	property p_max;
		startup_phase_o <= 4'h6;
	endproperty
	property p_rate;
		config_osc_rate_o <= 3'h5;
	endproperty
	property p_rate_load;
		$changed(config_osc_rate_o) |-> $past(global_set_reset_o);
	endproperty
	property p_gsr_quiet;
		global_set_reset_o |-> startup_phase_o == 4'h0 && !global_write_enable_o && global_tristate_o;
	endproperty
	property p_gsr_hold;
		$rose(global_set_reset_o) |=> global_set_reset_o;
	endproperty
	property p_we_stand;
		$fell(global_write_enable_o) || $rose(global_tristate_o) |-> global_set_reset_o;
	endproperty
	property p_done_rel;
		$rose(done_pin_oe_n_o) |-> startup_phase_o != 4'h0 && !global_set_reset_o;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and OKAY");
	a_step: assert property (p_step) else $error("phase moved by more than one");
	a_max: assert property (p_max) else $error("phase above six");
	a_rate: assert property (p_rate) else $error("rate code out of range");
	a_rate_load: assert property (p_rate_load) else $error("rate changed outside load end");
	a_gsr_quiet: assert property (p_gsr_quiet) else $error("releases active under set/reset");
	a_gsr_hold: assert property (p_gsr_hold) else $error("set/reset too short");
	a_we_stand: assert property (p_we_stand) else $error("release withdrawn outside load");
	a_done_rel: assert property (p_done_rel) else $error("done released at phase zero");
	c_we: cover property ($rose(global_write_enable_o));
	c_done: cover property ($rose(done_pin_oe_n_o));
	c_gsr: cover property ($fell(global_set_reset_o));
endmodule // css_seq_chk

bind css_config_startup_sequencer css_seq_chk u_chk (.clock_i(clock_i), .reset_i(reset_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .done_pin_oe_n_o(done_pin_oe_n_o),
	.global_tristate_o(global_tristate_o), .global_write_enable_o(global_write_enable_o),
	.global_set_reset_o(global_set_reset_o), .config_osc_rate_o(config_osc_rate_o),
	.startup_phase_o(startup_phase_o));

// ---- testbench/css_host_model.sv ----
// Far-side model: makes the three startup clocks and the pulled-up completion pin.
// Assumes step is called just after a rising edge of clock_i.
`timescale 1ns/1ps
module css_host_model (
	input wire logic clock_i,
	input wire logic done_pin_oe_n_i,
	input wire logic hold_low_i,
	output logic cclk_o,
	output logic user_clk_o,
	output logic tck_o,
	output logic done_pin_o
);
	// ==========================================================================
	// Clocks and pin.
	logic [2:0] clk_reg = 3'h0;
	assign {tck_o, user_clk_o, cclk_o} = clk_reg;
	// Open drain with a pull-up: it reads high unless somebody pulls it low.
	assign done_pin_o = done_pin_oe_n_i & ~hold_low_i;
	// Clocks stand low between steps so that no stray level counts as an edge.
	task automatic step(input int s);
		clk_reg[s] <= 1'b1;
		@(posedge clock_i);
		clk_reg[s] <= 1'b0;
		@(posedge clock_i);
		@(posedge clock_i);
	endtask
endmodule // css_host_model

// ---- testbench/tb_config_startup_sequencer.sv ----
// Self-checking bench: bus tasks, startup runs on each clock source, readback.
// Assumes a zero-wait bus slave and the host model driving the startup clocks.
`timescale 1ns/1ps
module tb_config_startup_sequencer;
	import css_pkg::*;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, capture = 1'b0, hold_low = 1'b0;
	logic [1:0] htrans = 2'h0, rb_port = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, flops = 32'h1234_5678, lut = 32'h0bad_f00d;
	logic [31:0] bmem = 32'h5a5a_a5a5, rd;
	logic [31:0] rb_exp [4] = '{32'h0001_0457, 32'h1234_5678, 32'h0bad_f00d, 32'h5a5a_a5a5};
	logic hready, hresp, done_oe_n, done_lvl, global_tristate, global_write_enable, global_set_reset, cclk, uclk, tck, done_drv;
	logic [31:0] hrdata;
	logic [2:0] rate;
	logic [1:0] pull;
	logic [3:0] phase;
	int n_errors = 0, checks = 0, cyc = 0;
	wire [31:0] outs = {19'h0, pull, rate, done_oe_n, global_tristate, global_write_enable, global_set_reset, phase};
	// ==========================================================================
	// Design, host and tasks.
	css_config_startup_sequencer dut (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(CSS_HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .rb_port_i(rb_port), .cclk_i(cclk),
		.user_clk_i(uclk), .tck_i(tck), .capture_i(capture), .user_flops_i(flops), .lut_mem_i(lut),
		.block_mem_i(bmem), .done_pin_i(done_lvl), .done_pin_o(done_drv), .done_pin_oe_n_o(done_oe_n),
		.global_tristate_o(global_tristate), .global_write_enable_o(global_write_enable), .global_set_reset_o(global_set_reset),
		.config_osc_rate_o(rate), .unused_pin_pull_sel_o(pull), .startup_phase_o(phase));
	css_host_model host (.clock_i(clock_i), .done_pin_oe_n_i(done_oe_n), .hold_low_i(hold_low),
		.cclk_o(cclk), .user_clk_o(uclk), .tck_o(tck), .done_pin_o(done_lvl));
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= CSS_HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clock_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Loads, steps the wrong source once, then walks six phases on the chosen source.
	task automatic run(input logic [31:0] cfg, input logic [3:0] wep, input logic [3:0] tsp, input int src);
		xfer(1'b1, CSS_CFG_OFS, cfg);
		xfer(1'b1, CSS_CMD_OFS, 32'h1);
		xfer(1'b1, CSS_CMD_OFS, 32'h2);
		chk({31'h0, global_set_reset}, 32'h1, "set/reset during load");
		repeat (2) @(posedge clock_i);
		host.step((src + 1) % 3);
		for (int k = 0; k <= 6; k++) begin
			if (k > 0)
				host.step(src);
			chk(outs, {19'h0, cfg[15:14], cfg[18:16], 1'(k >= cfg[11:8]), 1'(k < tsp), 1'(k >= wep), 1'b0,
				4'(k)}, "phase walk");
		end
		$display("test run done");
	endtask
	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		chk(outs, {19'h0, CSS_PULL_DOWN, CSS_RATE_LOWEST, 4'h4, 4'h0}, "reset outputs");
		chk({31'h0, done_drv}, 32'h0, "completion pin drive level");
		xfer(1'b0, CSS_CFG_OFS, 32'h0);
		chk(rd, CSS_CFG_RESET, "settings reset");
		$display("test reset done");
		run(32'h0003_0456, 4'h6, 4'h5, 0);
		run(32'h0005_5321, 4'h1, 4'h2, 1);
		run(32'h0002_a418, 4'h1, 4'h1, 2);
		hold_low <= 1'b1;
		run(32'h0001_0457, 4'h7, 4'h5, 0);
		hold_low <= 1'b0;
		host.step(0);
		chk({31'h0, global_write_enable}, 32'h1, "write enable after done");
		capture <= 1'b1;
		@(posedge clock_i);
		capture <= 1'b0;
		flops <= 32'h0;
		lut <= 32'h0;
		for (int s = 0; s < 4; s++) begin
			xfer(1'b1, CSS_RBSEL_OFS, 32'(s));
			xfer(1'b0, CSS_RBDATA_OFS, 32'h0);
			chk(rd, rb_exp[s], "readback source");
		end
		rb_port <= 2'h2;
		xfer(1'b0, CSS_RBDATA_OFS, 32'h0);
		chk(rd, 32'h0, "readback other port");
		xfer(1'b0, CSS_STAT_OFS, 32'h0);
		chk({31'h0, rd[13]}, 32'h1, "refused flag set");
		rb_port <= CSS_PORT_JTAG;
		xfer(1'b0, CSS_RBDATA_OFS, 32'h0);
		chk(rd, bmem, "readback jtag");
		xfer(1'b1, CSS_CMD_OFS, 32'h4);
		xfer(1'b0, CSS_STAT_OFS, 32'h0);
		chk({30'h0, rd[13:12]}, 32'h1, "refused flag cleared, readback allowed");
		xfer(1'b1, CSS_CFG_OFS, 32'h0011_0457);
		xfer(1'b0, CSS_RBDATA_OFS, 32'h0);
		chk(rd, 32'h0, "readback locked");
		xfer(1'b1, 8'h40, 32'hffff_ffff);
		xfer(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("test readback done");
		summarize();
	end
endmodule // tb_config_startup_sequencer
